// ===== common/wsc_consts.vh
`ifndef WSC_CONSTS_VH
`define WSC_CONSTS_VH
// register addresses on the internal register port
`define WSC_ADDR_INT_WAKE 7'h06
`define WSC_ADDR_EXT_WAKE 7'h07
`define WSC_ADDR_PULL 7'h08
`define WSC_ADDR_FILT 7'h09
// internal wake control fields
`define WSC_INT_T2_BIT 7
`define WSC_INT_T1_BIT 6
`define WSC_INT_WD_BIT 2
`define WSC_INT_WMASK 8'hC4
`define WSC_INT_RESTART_KEEP 8'hC0
// external wake control fields
`define WSC_EXT_GLOBAL_BIT 7
`define WSC_EXT_MEAS_BIT 5
`define WSC_EXT_WMASK 8'hA7
`define WSC_EXT_RESTART_KEEP 8'hA7
`define WSC_EXT_FAILSAFE_KEEP 8'hA0
`define WSC_EXT_FAILSAFE_SET 8'h07
// pull and filter registers
`define WSC_CFG_WMASK 8'h3F
`define WSC_CFG_RESTART_KEEP 8'h3F
// reset values
`define WSC_INT_RESET 8'h00
`define WSC_EXT_RESET 8'h07
`define WSC_CFG_RESET 8'h00
// filter codes
`define WSC_FLT_STATIC_SHORT 2'h0
`define WSC_FLT_STATIC_LONG 2'h1
`define WSC_FLT_CYCLIC_T1 2'h2
`define WSC_FLT_CYCLIC_T2 2'h3
// filter times and clock period in ns
`define WSC_CLK_PERIOD_NS 100
`define WSC_FLT_SHORT_NS 16000
`define WSC_FLT_LONG_NS 64000
`define WSC_FLT_SHORT_CYC ((`WSC_FLT_SHORT_NS + `WSC_CLK_PERIOD_NS - 1) / `WSC_CLK_PERIOD_NS)
`define WSC_FLT_LONG_CYC ((`WSC_FLT_LONG_NS + `WSC_CLK_PERIOD_NS - 1) / `WSC_CLK_PERIOD_NS)
`endif

// ===== core/wsc_wake_regs.v
// What this block does
// R1 - second timer wakes only while internal control bit 7 is one
// R2 - first timer wakes only while internal control bit 6 is one
// R3 - internal bit 2 deactivates stop-mode watchdog; device may set it itself
// R4 - reserved bits read zero; writes to them are ignored
// R5 - global bit zero: only wakes interrupt; one: any status bit interrupts
// R6 - measurement select makes inputs one and two ignore their wake enables
// R7 - measurement runs in normal mode; input one/two levels then ignored
// R8 - external bits 2,1,0 enable wake inputs three, two, one
// R9 - fail-safe entry forces external register to x0x0 0111
// R10 - power-on or soft reset: external 0x07, others zero
// R11 - restart keeps external bits 7,5,2,1,0 and clears the rest
// R12 - restart keeps timer wake enables, clears internal bits 5 to 0
// R13 - two-bit pull field per input: none, down, up, automatic
// R14 - filter code 00: static sensing, short filter time
// R15 - filter code 01: static sensing, long filter time
// R16 - filter code 10: cyclic sensing, short filter at first timer on-time end
// R17 - filter code 11: cyclic sensing, short filter at second timer on-time end
// R18 - host assigns the timer to a high-side switch before cyclic sensing
// R19 - restart keeps pull and filter bits 5:0, clears bits 7:6
// R20 - serial writes take effect when chip select returns high
// R21 - accepted change on enabled input sets wake status and interrupts
`include "wsc_consts.vh"
`default_nettype none

module wsc_wake_regs #(
  parameter SHORT_CYC = `WSC_FLT_SHORT_CYC,
  parameter LONG_CYC = `WSC_FLT_LONG_CYC
) (
  input wire clk,
  input wire nrst,
  input wire soft_reset,
  input wire restart,
  input wire failsafe_entry,
  input wire chip_select_low,
  input wire wr_en,
  input wire [6:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [6:0] rd_addr,
  output reg [7:0] rd_data,
  input wire stop_watchdog_set,
  input wire stop_watchdog_clr,
  input wire normal_mode,
  input wire first_cyclic_timer_wake,
  input wire second_cyclic_timer_wake,
  input wire first_timer_on_end,
  input wire second_timer_on_end,
  input wire wake_input_one,
  input wire wake_input_two,
  input wire wake_input_three,
  input wire other_status_event,
  input wire status_clear,
  output reg [2:0] input_wake_status,
  output reg timer_wake_status,
  output reg [2:0] wake_level,
  output reg measurement_active,
  output reg stop_watchdog_off_high,
  output reg [5:0] pull_config,
  output reg int_out
);

  reg [7:0] int_wake_reg;
  reg [7:0] ext_wake_reg;
  reg [7:0] pull_reg;
  reg [7:0] filt_reg;
  reg pend_valid_reg;
  reg [6:0] pend_addr_reg;
  reg [7:0] pend_data_reg;
  reg cs_prev_reg;
  reg other_pend_reg;

  wire second_timer_wake_enable = int_wake_reg[`WSC_INT_T2_BIT];
  wire first_timer_wake_enable = int_wake_reg[`WSC_INT_T1_BIT];
  wire global_int = ext_wake_reg[`WSC_EXT_GLOBAL_BIT];
  wire measurement_select = ext_wake_reg[`WSC_EXT_MEAS_BIT];
  wire input_one_wake_enable = ext_wake_reg[0];
  wire input_two_wake_enable = ext_wake_reg[1];
  wire input_three_wake_enable = ext_wake_reg[2];
  wire cs_rise = chip_select_low & ~cs_prev_reg;
  wire commit = cs_rise & pend_valid_reg;
  wire [2:0] wake_in = {wake_input_three, wake_input_two, wake_input_one};
  wire [2:0] in_enable;
  wire [2:0] accepted;
  wire timer_wake;

  // measurement overrides enables of inputs one and two
  assign in_enable = {input_three_wake_enable,
                      input_two_wake_enable & ~measurement_select,
                      input_one_wake_enable & ~measurement_select}; // R6 R8
  assign timer_wake = (second_cyclic_timer_wake & second_timer_wake_enable) |
                      (first_cyclic_timer_wake & first_timer_wake_enable); // R1 R2

  // hold written data until chip select rises
  always @(posedge clk) begin
    if (!nrst) begin
      cs_prev_reg <= 1'b1;
      pend_valid_reg <= 1'b0;
      pend_addr_reg <= 7'h00;
      pend_data_reg <= 8'h00;
    end else begin
      cs_prev_reg <= chip_select_low;
      if (wr_en) begin
        pend_valid_reg <= 1'b1;
        pend_addr_reg <= wr_addr;
        pend_data_reg <= wr_data;
      end else if (commit) begin
        pend_valid_reg <= 1'b0; // R20
      end
    end
  end

  always @(posedge clk) begin
    if (!nrst || soft_reset) begin
      int_wake_reg <= `WSC_INT_RESET; // R10
      ext_wake_reg <= `WSC_EXT_RESET; // R10
      pull_reg <= `WSC_CFG_RESET;
      filt_reg <= `WSC_CFG_RESET;
    end else if (failsafe_entry) begin
      ext_wake_reg <= (ext_wake_reg & `WSC_EXT_FAILSAFE_KEEP) | `WSC_EXT_FAILSAFE_SET; // R9
    end else if (restart) begin
      int_wake_reg <= int_wake_reg & `WSC_INT_RESTART_KEEP; // R12
      ext_wake_reg <= ext_wake_reg & `WSC_EXT_RESTART_KEEP; // R11
      pull_reg <= pull_reg & `WSC_CFG_RESTART_KEEP; // R19
      filt_reg <= filt_reg & `WSC_CFG_RESTART_KEEP; // R19
    end else begin
      if (commit) begin
        case (pend_addr_reg)
          `WSC_ADDR_INT_WAKE: int_wake_reg <= pend_data_reg & `WSC_INT_WMASK; // R4 R20
          `WSC_ADDR_EXT_WAKE: ext_wake_reg <= pend_data_reg & `WSC_EXT_WMASK; // R4 R20
          `WSC_ADDR_PULL: pull_reg <= pend_data_reg & `WSC_CFG_WMASK; // R4 R20
          `WSC_ADDR_FILT: filt_reg <= pend_data_reg & `WSC_CFG_WMASK; // R4 R20
          default: ;
        endcase
      end
      // device-side update of stop watchdog bit wins over a write
      if (stop_watchdog_set)
        int_wake_reg[`WSC_INT_WD_BIT] <= 1'b1; // R3
      else if (stop_watchdog_clr)
        int_wake_reg[`WSC_INT_WD_BIT] <= 1'b0; // R3
    end
  end

  always @* begin
    case (rd_addr)
      `WSC_ADDR_INT_WAKE: rd_data = int_wake_reg; // R4
      `WSC_ADDR_EXT_WAKE: rd_data = ext_wake_reg;
      `WSC_ADDR_PULL: rd_data = pull_reg;
      `WSC_ADDR_FILT: rd_data = filt_reg;
      default: rd_data = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      measurement_active <= 1'b0;
      stop_watchdog_off_high <= 1'b0;
      pull_config <= 6'h00;
    end else begin
      measurement_active <= measurement_select & normal_mode; // R7
      stop_watchdog_off_high <= int_wake_reg[`WSC_INT_WD_BIT]; // R3
      pull_config <= pull_reg[5:0]; // R13
    end
  end

  // per-input level filter
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_in
      reg [9:0] cnt_reg;
      reg level_reg;
      reg armed_reg;
      reg acc_reg;
      wire [1:0] code = filt_reg[2*i+1:2*i];
      wire [9:0] limit = (code == `WSC_FLT_STATIC_LONG) ? LONG_CYC[9:0] : SHORT_CYC[9:0]; // R14 R15
      wire cyclic = code[1];
      wire window_end = (code == `WSC_FLT_CYCLIC_T1) ? first_timer_on_end :
                        second_timer_on_end; // R16 R17
      wire stable = (cnt_reg >= limit);
      always @(posedge clk) begin
        if (!nrst) begin
          cnt_reg <= 10'h000;
          level_reg <= 1'b0;
          armed_reg <= 1'b0;
          acc_reg <= 1'b0;
        end else begin
          acc_reg <= 1'b0;
          if (wake_in[i] == level_reg) begin
            cnt_reg <= 10'h000;
          end else if (!stable) begin
            cnt_reg <= cnt_reg + 10'h001;
          end
          if (!cyclic) begin
            armed_reg <= 1'b0;
            if (wake_in[i] != level_reg && stable) begin
              level_reg <= wake_in[i]; // R14 R15
              acc_reg <= 1'b1;
              cnt_reg <= 10'h000;
            end
          end else begin
            // filter starts with the on-time end
            if (window_end) begin
              armed_reg <= 1'b1;
              cnt_reg <= 10'h000;
            end else if (armed_reg && wake_in[i] == level_reg) begin
              armed_reg <= 1'b0;
            end else if (armed_reg && stable) begin
              level_reg <= wake_in[i]; // R16 R17
              acc_reg <= 1'b1;
              armed_reg <= 1'b0;
              cnt_reg <= 10'h000;
            end
          end
        end
      end
      assign accepted[i] = acc_reg & in_enable[i]; // R21
    end
  endgenerate

  always @(posedge clk) begin
    if (!nrst) begin
      input_wake_status <= 3'h0;
      timer_wake_status <= 1'b0;
      wake_level <= 3'h0;
      other_pend_reg <= 1'b0;
      int_out <= 1'b0;
    end else begin
      // new events win over a clear in the same cycle
      input_wake_status <= (status_clear ? 3'h0 : input_wake_status) | accepted; // R21
      timer_wake_status <= (status_clear ? 1'b0 : timer_wake_status) | timer_wake;
      other_pend_reg <= (status_clear ? 1'b0 : other_pend_reg) | other_status_event;
      wake_level <= {g_in[2].level_reg,
                     g_in[1].level_reg & ~measurement_select,
                     g_in[0].level_reg & ~measurement_select}; // R7
      int_out <= (|accepted) | timer_wake | (global_int & other_status_event); // R5 R21
    end
  end

endmodule // wsc_wake_regs

`default_nettype wire

// ===== tb/wsc_wake_regs_props.sv
`default_nettype none
module wsc_wake_regs_props (
  input wire clk,
  input wire nrst,
  input wire soft_reset,
  input wire restart,
  input wire failsafe_entry,
  input wire normal_mode,
  input wire first_cyclic_timer_wake,
  input wire second_cyclic_timer_wake,
  input wire [6:0] rd_addr,
  input wire [7:0] rd_data,
  input wire [2:0] input_wake_status,
  input wire timer_wake_status,
  input wire [2:0] wake_level,
  input wire measurement_active,
  input wire stop_watchdog_off_high,
  input wire [5:0] pull_config,
  input wire int_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_RES: assert property (!(rd_addr == 7'h06 && |(rd_data & 8'h3B)) &&
    !(rd_addr == 7'h07 && |(rd_data & 8'h58)) && !(rd_addr[6:1] == 6'h04 && |rd_data[7:6]))
    else $error("reserved bit reads one");
  AST_TW: assert property ($rose(timer_wake_status) |->
    $past(first_cyclic_timer_wake || second_cyclic_timer_wake)) else $error("timer wake uncaused");
  AST_MEAS: assert property (measurement_active && $past(measurement_active) |->
    wake_level[1:0] == 2'h0) else $error("level shown in measurement");
  AST_INT: assert property (|(input_wake_status & ~$past(input_wake_status)) |-> int_out)
    else $error("wake without interrupt");
  AST_PULL: assert property (rd_addr == 7'h08 && $past(rd_addr) == 7'h08 && $stable(rd_data)
    |-> pull_config == rd_data[5:0]) else $error("pull output differs");
  AST_WD: assert property (rd_addr == 7'h06 && $past(rd_addr) == 7'h06 && $stable(rd_data)
    |-> stop_watchdog_off_high == rd_data[2]) else $error("watchdog output differs");
  AST_MACT: assert property (rd_addr == 7'h07 && $past(rd_addr) == 7'h07 && $stable(rd_data)
    && $stable(normal_mode) |-> measurement_active == (rd_data[5] & normal_mode))
    else $error("measurement output wrong");
  AST_FS: assert property (failsafe_entry && !restart && !soft_reset && rd_addr == 7'h07
    |=> rd_addr != 7'h07 || (rd_data & 8'h5F) == 8'h07) else $error("fail-safe value wrong");
  AST_RST: assert property (restart && !soft_reset && !failsafe_entry && rd_addr == 7'h07
    |=> rd_addr != 7'h07 || rd_data == ($past(rd_data) & 8'hA7)) else $error("restart wrong");
endmodule // wsc_wake_regs_props
bind wsc_wake_regs wsc_wake_regs_props wsc_wake_regs_props_i (.clk(clk), .nrst(nrst),
  .soft_reset(soft_reset), .restart(restart), .failsafe_entry(failsafe_entry),
  .normal_mode(normal_mode), .first_cyclic_timer_wake(first_cyclic_timer_wake),
  .second_cyclic_timer_wake(second_cyclic_timer_wake), .rd_addr(rd_addr), .rd_data(rd_data),
  .input_wake_status(input_wake_status), .timer_wake_status(timer_wake_status),
  .wake_level(wake_level), .measurement_active(measurement_active),
  .stop_watchdog_off_high(stop_watchdog_off_high), .pull_config(pull_config), .int_out(int_out));
`default_nettype wire

// ===== tb/wsc_host.sv
`default_nettype none
module wsc_host (
  input wire logic clk,
  input wire logic [7:0] rd_data,
  output logic chip_select_low,
  output logic wr_en,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [6:0] rd_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    chip_select_low = 1'b1;
    wr_en = 1'b0;
    wr_addr = 7'h00;
    wr_data = 8'h00;
    rd_addr = 7'h00;
  end
  // leaves chip select low; write is pending until cm
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    chip_select_low = 1'b0;
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask
  task cm;
    @(negedge clk);
    chip_select_low = 1'b1;
    @(negedge clk);
  endtask
  task rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_addr = a;
    #1 d = rd_data;
  endtask
endmodule // wsc_host
`default_nettype wire

// ===== tb/wsc_wake_regs_test.sv
`default_nettype none
module wsc_wake_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int S = 4;
  localparam int L = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [10:0] p = 11'h000;
  logic nm = 1'b0;
  logic seen = 1'b0;
  logic [2:0] wk = 3'h0;
  logic [7:0] v;
  wire csl, we, tws, ma, swo, io;
  wire [6:0] wa, ra;
  wire [7:0] wd, rdd;
  wire [2:0] iws, wl;
  wire [5:0] pc;
  int n_errors = 0, compares = 0, cyc = 0;
  wsc_host wsc_host_i (.clk(clk), .rd_data(rdd), .chip_select_low(csl), .wr_en(we),
    .wr_addr(wa), .wr_data(wd), .rd_addr(ra));
  wsc_wake_regs #(.SHORT_CYC(S), .LONG_CYC(L)) wsc_wake_regs_i (.clk(clk), .nrst(nrst),
    .soft_reset(p[0]), .restart(p[1]), .failsafe_entry(p[2]), .chip_select_low(csl),
    .wr_en(we), .wr_addr(wa), .wr_data(wd), .rd_addr(ra), .rd_data(rdd),
    .stop_watchdog_set(p[3]), .stop_watchdog_clr(p[10]), .normal_mode(nm),
    .first_cyclic_timer_wake(p[4]), .second_cyclic_timer_wake(p[5]),
    .first_timer_on_end(p[6]), .second_timer_on_end(p[7]), .wake_input_one(wk[0]),
    .wake_input_two(wk[1]), .wake_input_three(wk[2]), .other_status_event(p[9]),
    .status_clear(p[8]), .input_wake_status(iws), .timer_wake_status(tws), .wake_level(wl),
    .measurement_active(ma), .stop_watchdog_off_high(swo), .pull_config(pc), .int_out(io));
  initial forever #50 clk = ~clk;
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task complete_run;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (io === 1'b1) seen <= 1'b1;
    if (cyc == 5000) begin
      n_errors++;
      complete_run;
    end
  end
  task pu(input int k);
    @(negedge clk);
    p[k] = 1'b1;
    @(negedge clk);
    p[k] = 1'b0;
  endtask
  task wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task w(input logic [6:0] a, input logic [7:0] d);
    wsc_host_i.wr(a, d);
    wsc_host_i.cm;
  endtask
  task rc(input logic [6:0] a, input logic [7:0] e);
    wsc_host_i.rd(a, v);
    chk("register", v, e);
  endtask
  task rv;
    for (int i = 0; i < 4; i++) rc(7'(6 + i), i == 1 ? 8'h07 : 8'h00);
    rc(7'h0A, 8'h00);
  endtask
  initial begin
    wt(3);
    nrst = 1'b1;
    rv;
    for (int i = 0; i < 4; i++) begin
      w(7'(6 + i), 8'hFF);
      rc(7'(6 + i), i == 0 ? 8'hC4 : i == 1 ? 8'hA7 : 8'h3F);
    end
    wsc_host_i.wr(7'h07, 8'h20);
    rc(7'h07, 8'hA7);
    wsc_host_i.cm;
    rc(7'h07, 8'h20);
    pu(1);
    rc(7'h07, 8'h20);
    rc(7'h06, 8'hC0);
    rc(7'h08, 8'h3F);
    w(7'h07, 8'hA0);
    rc(7'h07, 8'hA0);
    pu(2);
    rc(7'h07, 8'hA7);
    pu(0);
    rv;
    pu(3);
    rc(7'h06, 8'h04);
    chk("watchdog", {7'h0, swo}, 8'h01);
    pu(10);
    rc(7'h06, 8'h00);
    chk("watchdog", {7'h0, swo}, 8'h00);
    w(7'h08, 8'h1B);
    rc(7'h08, 8'h1B);
    chk("pull", {2'h0, pc}, 8'h1B);
    nm = 1'b1;
    w(7'h07, 8'h20);
    rc(7'h07, 8'h20);
    chk("meas", {7'h0, ma}, 8'h01);
    for (int i = 0; i < 2; i++) begin
      w(7'h06, 8'h00);
      pu(8);
      pu(4 + i);
      wt(2);
      chk("timer", {7'h0, tws}, 8'h00);
      w(7'h06, i ? 8'h80 : 8'h40);
      pu(4 + i);
      wt(2);
      chk("timer", {7'h0, tws}, 8'h01);
    end
    w(7'h07, 8'h01);
    for (int c = 0; c < 4; c++) begin
      w(7'h09, 8'(c));
      pu(8);
      seen = 1'b0;
      wk[0] = ~wk[0];
      if (c > 1) pu(4 + c);
      wt(S + 2);
      chk("filter", {7'h0, iws[0]}, {7'h0, c != 1});
      wt(L);
      chk("filter", {7'h0, iws[0]}, 8'h01);
      chk("level", {5'h0, wl}, {7'h0, wk[0]});
      chk("interrupt", {7'h0, seen}, 8'h01);
    end
    w(7'h09, 8'h00);
    for (int e = 0; e < 2; e++) begin
      w(7'h07, e ? 8'h21 : 8'h00);
      pu(8);
      wk[0] = ~wk[0];
      wt(S + 2);
      chk("disabled", {7'h0, iws[0]}, 8'h00);
    end
    for (int g = 0; g < 2; g++) begin
      w(7'h07, g ? 8'h80 : 8'h00);
      seen = 1'b0;
      pu(9);
      wt(3);
      chk("global", {7'h0, seen}, 8'(g));
    end
    complete_run;
  end
endmodule // wsc_wake_regs_test
`default_nettype wire
